// ---- verilog/wlio_pkg.sv ----
`default_nettype none
package wlio_pkg;
    localparam int NIN = 2;
    localparam int NOUT = 4;
    localparam int WW = 32;
    localparam int TW = 16;
    localparam int ACW = 5;
    typedef logic signed [WW-1:0] wlio_w_t;
    typedef enum logic [3:0] {
        IF_NONE = 4'h0, IF_TARE = 4'h1, IF_CTARE = 4'h2, IF_ZERO = 4'h3,
        IF_XMIT = 4'h4, IF_WIN = 4'h5, IF_DZERO = 4'h6, IF_START = 4'h7,
        IF_BRUN = 4'h8, IF_CLRT = 4'h9, IF_SIC = 4'hA, IF_BFAULT = 4'hB
    } wlio_in_fn_t;
    typedef enum logic [2:0] {
        OF_NONE = 3'h0, OF_SETP = 3'h1, OF_MOTION = 3'h2,
        OF_DEFECT = 3'h3, OF_IMAGE = 3'h4, OF_LEVEL = 3'h5
    } wlio_out_fn_t;
    typedef enum logic [1:0] {
        OM_XMTR = 2'h0, OM_BSCALE = 2'h1, OM_FEEDER = 2'h2
    } wlio_mode_t;
    typedef enum logic [1:0] {MS_GROSS = 2'h0, MS_NET = 2'h1, MS_FACT = 2'h2} wlio_meas_t;
    typedef enum logic [1:0] {
        SS_GROSS = 2'h0, SS_NET = 2'h1, SS_SIC = 2'h2, SS_BATCH = 2'h3
    } wlio_sp_src_t;
    typedef enum logic [2:0] {
        AS_NONE = 3'h0, AS_GROSS = 3'h1, AS_NET = 3'h2, AS_LEVEL = 3'h3,
        AS_FLOWCTL = 3'h4, AS_IFLOW = 3'h5, AS_AFLOW = 3'h6, AS_SPEED = 3'h7
    } wlio_ana_src_t;
    typedef enum logic [1:0] {AL_OFF = 2'h1, AL_ON = 2'h2} wlio_al_st_t;
    localparam wlio_w_t W_RST = 32'h0000_0000;
    localparam wlio_w_t ANA_ERR = 32'h8000_0000;
    localparam wlio_w_t RAMP_STEP = 32'h0000_0040;
    localparam logic [6:0] PCT_NORM = 7'h0A;
    localparam logic [6:0] PCT_LEGAL = 7'h02;
    localparam logic [6:0] PCT_SCALE = 7'h64;
    localparam logic [TW-1:0] CNT_RST = 16'h0000;
    localparam logic [TW-1:0] CNT_ONE = 16'h0001;
    localparam logic [ACW-1:0] ACFG_RST = 5'h00;
endpackage : wlio_pkg
`default_nettype wire

// ---- verilog/wlio_sp_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface wlio_sp_if;
    logic signed [wlio_pkg::WW-1:0] value;
    logic signed [wlio_pkg::WW-1:0] low;
    logic signed [wlio_pkg::WW-1:0] high;
    logic win;
    logic hit;
    modport cmp (input value, input low, input high, input win, output hit);
    modport src (output value, output low, output high, output win, input hit);
endinterface : wlio_sp_if
`default_nettype wire

// ---- verilog/wlio_in_cond.sv ----
`timescale 1ns/100ps
`default_nettype none
module wlio_in_cond (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic pin,
    input wire logic neg,
    input wire logic [wlio_pkg::TW-1:0] db_time,
    output logic phys,
    output logic lvl,
    output logic act
);
    import wlio_pkg::*;
    logic s1_r, s2_r, db_r, act_r;
    logic [TW-1:0] cnt_r;
    wire differ = s2_r != db_r;
    wire settle = differ && (cnt_r >= db_time);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            db_r <= 1'b0;
            act_r <= 1'b0;
            cnt_r <= CNT_RST;
        end else if (clk_en) begin
            s1_r <= pin; // see R24
            s2_r <= s1_r;
            cnt_r <= (differ && !settle) ? cnt_r + CNT_ONE : CNT_RST; // see R22
            if (settle) begin
                db_r <= s2_r;
            end
            act_r <= settle && (s2_r ^ neg); // see R1
        end
    end

    assign phys = db_r;
    assign lvl = db_r ^ neg;
    assign act = act_r;

    act_single_a: assert property (@(posedge ref_clk) disable iff (rst)
        act_r |-> lvl ##1 !act_r) else $error("input trigger not single"); // see R24
endmodule : wlio_in_cond
`default_nettype wire

// ---- verilog/wlio_setpoint.sv ----
`timescale 1ns/100ps
`default_nettype none
module wlio_setpoint (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    wlio_sp_if.cmp sp
);
    import wlio_pkg::*;
    logic hit_r;
    wire above = sp.value >= sp.high;
    wire below = sp.value <= sp.low;
    wire in_win = (sp.value >= sp.low) && (sp.value <= sp.high);
    wire hys_nxt = above ? 1'b1 : (below ? 1'b0 : hit_r);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hit_r <= 1'b0;
        end else if (clk_en) begin
            hit_r <= sp.win ? in_win : hys_nxt; // see R13
        end
    end

    assign sp.hit = hit_r;

    sp_window_a: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && sp.win |=> hit_r == $past(in_win)) else $error("window compare wrong"); // see R13
endmodule : wlio_setpoint
`default_nettype wire

// ---- verilog/wlio_top.sv ----
// Function
// R1: Tare input edge acquires tare, polarity-selected
// R2: Tare needs stability unless check disabled
// R3: Cancel-tare edge clears stored tare
// R4: Zero accepted within 10% or 2% capacity
// R5: Zero input edge triggers zero acquisition
// R6: One measurement sent per transmit edge
// R7: Window input repeats transmission each period
// R8: Both inputs window: only input 2 counts
// R9: Input functions gated by operating mode
// R10: Master runs sensor check only when idle
// R11: Each output has own polarity
// R12: Set point output n follows set point n
// R13: Set point is hysteresis or window comparator
// R14: Set point source gross, net, check, batch
// R15: Motion output reflects stability indication
// R16: Defect output follows integrity alarm only
// R17: Image outputs mirror inputs, direct or inverted
// R18: Level-on-request output follows master level
// R19: Analog weight or flow shows error on alarm
// R20: Analog range and enables apply after reset
// R21: Flow control output ramps up and down
// R22: Per-input polarity, common debounce time
// R23: Alarm has debounce and minimum activation time
// R24: Inputs synchronised, one trigger per edge
`timescale 1ns/100ps
`default_nettype none
module wlio_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [wlio_pkg::NIN-1:0] in_pin,
    input wire logic [wlio_pkg::NIN-1:0] in_neg,
    input wire logic [wlio_pkg::TW-1:0] db_time,
    input wire wlio_pkg::wlio_in_fn_t in_fn [wlio_pkg::NIN],
    input wire wlio_pkg::wlio_mode_t op_mode,
    input wire logic stab_en,
    input wire logic stable,
    input wire logic legal_trade,
    input wire logic [wlio_pkg::WW-1:0] capacity,
    input wire wlio_pkg::wlio_w_t raw_gross,
    input wire wlio_pkg::wlio_w_t factory,
    input wire wlio_pkg::wlio_meas_t meas_sel,
    input wire logic [wlio_pkg::TW-1:0] sample_period,
    input wire wlio_pkg::wlio_w_t sic_result,
    input wire wlio_pkg::wlio_w_t batch_val,
    input wire wlio_pkg::wlio_out_fn_t out_fn [wlio_pkg::NOUT],
    input wire logic [wlio_pkg::NOUT-1:0] out_neg,
    input wire wlio_pkg::wlio_sp_src_t sp_src [wlio_pkg::NOUT],
    input wire wlio_pkg::wlio_w_t sp_low [wlio_pkg::NOUT],
    input wire wlio_pkg::wlio_w_t sp_high [wlio_pkg::NOUT],
    input wire logic [wlio_pkg::NOUT-1:0] sp_win,
    input wire logic [wlio_pkg::NOUT-1:0] master_lvl,
    input wire logic raw_alarm,
    input wire logic [wlio_pkg::TW-1:0] al_db_time,
    input wire logic [wlio_pkg::TW-1:0] al_min_time,
    input wire wlio_pkg::wlio_ana_src_t ana_src,
    input wire logic [wlio_pkg::ACW-1:0] ana_cfg,
    input wire wlio_pkg::wlio_w_t ana_req,
    input wire wlio_pkg::wlio_w_t flow_cmd,
    input wire logic flow_run,
    input wire wlio_pkg::wlio_w_t iflow,
    input wire wlio_pkg::wlio_w_t aflow,
    input wire wlio_pkg::wlio_w_t speed,
    output logic [wlio_pkg::NOUT-1:0] out_pin,
    output wlio_pkg::wlio_w_t gross_out,
    output wlio_pkg::wlio_w_t net_out,
    output wlio_pkg::wlio_w_t tare_out,
    output wlio_pkg::wlio_w_t zero_out,
    output logic zero_rej,
    output logic xmit_p,
    output wlio_pkg::wlio_w_t xmit_val,
    output logic sic_p,
    output logic dzero_p,
    output logic start_p,
    output logic clrt_p,
    output logic brun_lvl,
    output logic bfault_lvl,
    output logic alarm,
    output wlio_pkg::wlio_w_t ana_val,
    output logic [wlio_pkg::ACW-1:0] ana_cfg_act
);
    import wlio_pkg::*;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [NIN-1:0] phys_w, lvl_w, act_w;
    wlio_in_fn_t fe_w [NIN];
    wlio_in_fn_t g0_w, g1_w;

    function automatic wlio_in_fn_t fn_gate(wlio_mode_t m, wlio_in_fn_t f);
        logic belt_only;
        logic xm_only;
        belt_only = f inside {IF_DZERO, IF_START, IF_BRUN, IF_CLRT, IF_BFAULT};
        xm_only = f inside {IF_XMIT, IF_WIN};
        fn_gate = ((m == OM_XMTR) ? belt_only : xm_only) ? IF_NONE : f;
    endfunction : fn_gate

    // Selections passed in, so the assigns below see every change
    function automatic logic [NIN-1:0] pick(wlio_in_fn_t f, wlio_in_fn_t a, wlio_in_fn_t b);
        pick = {b == f, a == f};
    endfunction : pick

    // Shared debounce time, own polarity per input
    for (genvar i = 0; i < NIN; i++) begin : g_in
        wlio_in_cond u_in ( // see R22
            .ref_clk(ref_clk),
            .rst(rst),
            .clk_en(clk_en),
            .pin(in_pin[i]),
            .neg(in_neg[i]),
            .db_time(db_time),
            .phys(phys_w[i]),
            .lvl(lvl_w[i]),
            .act(act_w[i])
        );
    end

    assign g0_w = fn_gate(op_mode, in_fn[0]); // see R9
    assign g1_w = fn_gate(op_mode, in_fn[1]); // see R9
    wire both_win = (g0_w == IF_WIN) && (g1_w == IF_WIN);
    assign fe_w[0] = both_win ? IF_NONE : g0_w; // see R8
    assign fe_w[1] = g1_w;

    wire tare_go = |(act_w & pick(IF_TARE, fe_w[0], fe_w[1])); // see R1
    wire ctare_go = |(act_w & pick(IF_CTARE, fe_w[0], fe_w[1])); // see R3
    wire zero_go = |(act_w & pick(IF_ZERO, fe_w[0], fe_w[1])); // see R5
    wire xmit_edge = |(act_w & pick(IF_XMIT, fe_w[0], fe_w[1])); // see R6
    wire win_lvl = |(lvl_w & pick(IF_WIN, fe_w[0], fe_w[1])); // see R7
    wire sic_go = |(act_w & pick(IF_SIC, fe_w[0], fe_w[1])); // see R10
    wire dz_go = |(act_w & pick(IF_DZERO, fe_w[0], fe_w[1]));
    wire st_go = |(act_w & pick(IF_START, fe_w[0], fe_w[1]));
    wire clrt_go = |(act_w & pick(IF_CLRT, fe_w[0], fe_w[1]));
    wire brun_w = |(lvl_w & pick(IF_BRUN, fe_w[0], fe_w[1]));
    wire bflt_w = |(lvl_w & pick(IF_BFAULT, fe_w[0], fe_w[1]));

    wlio_w_t gross_r, net_r, tare_r, zero_r, xval_r;
    logic zrej_r, xmit_r, sic_r, dz_r, st_r, clrt_r, brun_r, bflt_r;

    // Weighing values, tare and zero
    wire stab_ok = !stab_en || stable; // see R2
    wire [6:0] zpct = legal_trade ? PCT_LEGAL : PCT_NORM;
    wire [WW-1:0] zabs = raw_gross[WW-1] ? WW'(-raw_gross) : WW'(raw_gross);
    wire [WW+6:0] zabs_x = {7'h00, zabs} * {{WW{1'b0}}, PCT_SCALE};
    wire [WW+6:0] zlim = {7'h00, capacity} * {{WW{1'b0}}, zpct};
    // Multiply both sides so no divider is needed
    wire zero_ok = stab_ok && (zabs_x <= zlim); // see R4

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gross_r <= W_RST;
            net_r <= W_RST;
            tare_r <= W_RST;
            zero_r <= W_RST;
            zrej_r <= 1'b0;
        end else if (clk_en) begin
            gross_r <= raw_gross - zero_r;
            net_r <= gross_r - tare_r;
            if (ctare_go) begin
                tare_r <= W_RST; // see R3
            end
            // Acquisition wins a same-cycle cancel
            if (tare_go && stab_ok) begin
                tare_r <= gross_r; // see R1 R2
            end
            if (zero_go && zero_ok) begin
                zero_r <= raw_gross; // see R4 R5
            end
            zrej_r <= zero_go && !zero_ok;
        end
    end

    // Measurement transmission
    logic win_prev_r;
    logic [TW-1:0] win_cnt_r;
    wire [TW-1:0] win_inc = win_cnt_r + CNT_ONE;
    wire win_tick = win_lvl && (!win_prev_r || (win_inc >= sample_period)); // see R7
    wire xmit_go = xmit_edge || win_tick; // see R6
    wlio_w_t meas_w;
    assign meas_w = (meas_sel == MS_NET) ? net_r : ((meas_sel == MS_FACT) ? factory : gross_r);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            win_prev_r <= 1'b0;
            win_cnt_r <= CNT_RST;
            xmit_r <= 1'b0;
            xval_r <= W_RST;
        end else if (clk_en) begin
            win_prev_r <= win_lvl;
            win_cnt_r <= (win_tick || !win_lvl) ? CNT_RST : win_inc; // see R7
            xmit_r <= xmit_go;
            if (xmit_go) begin
                xval_r <= meas_w; // see R6
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {sic_r, dz_r, st_r, clrt_r, brun_r, bflt_r} <= 6'h00;
        end else if (clk_en) begin
            {sic_r, dz_r, st_r, clrt_r, brun_r, bflt_r} <=
                {sic_go, dz_go, st_go, clrt_go, brun_w, bflt_w}; // see R9
        end
    end

    // Integrity alarm debounce and minimum on-time
    wlio_al_st_t al_st_r, al_st_nxt;
    logic [TW-1:0] al_cnt_r, al_on_r;
    logic alarm_r;
    wire al_now = al_st_r == AL_ON;
    wire al_diff = raw_alarm != al_now;
    wire al_min_met = al_on_r >= al_min_time;
    wire al_settle = al_diff && (al_cnt_r >= al_db_time) && (!al_now || al_min_met); // see R23

    always_comb begin
        al_st_nxt = al_st_r;
        case (al_st_r)
            AL_OFF: begin
                if (al_settle) al_st_nxt = AL_ON;
            end
            AL_ON: begin
                if (al_settle) al_st_nxt = AL_OFF;
            end
            default: begin
                al_st_nxt = AL_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            al_st_r <= AL_OFF;
            al_cnt_r <= CNT_RST;
            al_on_r <= CNT_RST;
            alarm_r <= 1'b0;
        end else if (clk_en) begin
            al_st_r <= al_st_nxt;
            // Saturate so a long wait cannot wrap the count
            al_cnt_r <= (!al_diff || al_settle) ? CNT_RST :
                ((al_cnt_r >= al_db_time) ? al_cnt_r : al_cnt_r + CNT_ONE);
            al_on_r <= !al_now ? CNT_RST : (al_min_met ? al_on_r : al_on_r + CNT_ONE);
            alarm_r <= al_st_nxt == AL_ON; // see R23
        end
    end

    // Outputs
    wlio_sp_if sp_if [NOUT] ();
    logic [NOUT-1:0] hit_w, olvl_w, out_r;

    for (genvar i = 0; i < NOUT; i++) begin : g_out
        assign sp_if[i].value = (sp_src[i] == SS_NET) ? net_r : // see R14
            ((sp_src[i] == SS_SIC) ? sic_result :
            ((sp_src[i] == SS_BATCH) ? batch_val : gross_r));
        assign sp_if[i].low = sp_low[i];
        assign sp_if[i].high = sp_high[i];
        assign sp_if[i].win = sp_win[i];
        wlio_setpoint u_sp (
            .ref_clk(ref_clk),
            .rst(rst),
            .clk_en(clk_en),
            .sp(sp_if[i].cmp)
        );
        assign hit_w[i] = sp_if[i].hit; // see R12
        assign olvl_w[i] = (out_fn[i] == OF_SETP) ? hit_w[i] :
            (out_fn[i] == OF_MOTION) ? !stable : // see R15
            (out_fn[i] == OF_DEFECT) ? alarm_r : // see R16
            (out_fn[i] == OF_IMAGE) ? phys_w[i % NIN] : // see R17
            (out_fn[i] == OF_LEVEL) ? master_lvl[i] : 1'b0; // see R18
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_r <= 4'h0;
        end else if (clk_en) begin
            out_r <= olvl_w ^ out_neg; // see R11
        end
    end

    // Analog output source and ramp
    wlio_w_t ramp_r, ana_r;
    logic [ACW-1:0] acfg_r;
    wire ana_errsrc = ana_src inside {AS_GROSS, AS_NET, AS_IFLOW, AS_AFLOW};
    wlio_w_t ramp_tgt, ramp_gap, ramp_nxt, ana_nxt;
    assign ramp_tgt = flow_run ? flow_cmd : W_RST;
    wire ramp_up = ramp_r < ramp_tgt;
    assign ramp_gap = ramp_up ? ramp_tgt - ramp_r : ramp_r - ramp_tgt;
    assign ramp_nxt = (ramp_gap <= RAMP_STEP) ? ramp_tgt : // see R21
        (ramp_up ? ramp_r + RAMP_STEP : ramp_r - RAMP_STEP);
    assign ana_nxt = (alarm_r && ana_errsrc) ? ANA_ERR : // see R19
        (ana_src == AS_GROSS) ? gross_r :
        (ana_src == AS_NET) ? net_r :
        (ana_src == AS_LEVEL) ? ana_req :
        (ana_src == AS_FLOWCTL && op_mode != OM_XMTR) ? ramp_r :
        (ana_src == AS_IFLOW) ? iflow :
        (ana_src == AS_AFLOW) ? aflow :
        (ana_src == AS_SPEED) ? speed : W_RST;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Range and enables sampled only while in reset
            acfg_r <= ana_cfg; // see R20
            ramp_r <= W_RST;
            ana_r <= W_RST;
        end else if (clk_en) begin
            ramp_r <= ramp_nxt; // see R21
            ana_r <= ana_nxt;
        end
    end

    assign out_pin = out_r;
    assign gross_out = gross_r;
    assign net_out = net_r;
    assign tare_out = tare_r;
    assign zero_out = zero_r;
    assign zero_rej = zrej_r;
    assign xmit_p = xmit_r;
    assign xmit_val = xval_r;
    assign sic_p = sic_r;
    assign dzero_p = dz_r;
    assign start_p = st_r;
    assign clrt_p = clrt_r;
    assign brun_lvl = brun_r;
    assign bfault_lvl = bflt_r;
    assign alarm = alarm_r;
    assign ana_val = ana_r;
    assign ana_cfg_act = acfg_r;

    sequence s_win_start;
        clk_en && win_lvl && !win_prev_r;
    endsequence

    sequence s_tare_req;
        clk_en && tare_go;
    endsequence

    tare_acq_a: assert property ((s_tare_req and stab_ok) |=> tare_r == $past(gross_r))
        else $error("tare not acquired"); // see R1
    tare_wait_a: assert property ((s_tare_req and (!stab_ok && !ctare_go)) |=> $stable(tare_r))
        else $error("tare taken while unstable"); // see R2
    tare_clear_a: assert property (clk_en && ctare_go && !tare_go |=> tare_r == W_RST)
        else $error("tare not cleared"); // see R3
    zero_take_a: assert property (clk_en && zero_go |=>
        (zero_r == $past(raw_gross)) == $past(zero_ok) || $past(zero_r == raw_gross))
        else $error("zero range check wrong"); // see R4
    xmit_edge_a: assert property (clk_en && xmit_edge |=> xmit_r && xval_r == $past(meas_w))
        else $error("edge transmit missing"); // see R6
    win_start_a: assert property (s_win_start |=> xmit_r)
        else $error("window did not start"); // see R7
    win_pair_a: assert property (clk_en && both_win && !lvl_w[1] |=> !xmit_r)
        else $error("input 1 window not ignored"); // see R8
    mode_gate_a: assert property (clk_en && op_mode == OM_XMTR |=> !dz_r && !st_r && !clrt_r)
        else $error("belt function in transmitter mode"); // see R9
    out_setp_a: assert property (clk_en && out_fn[0] == OF_SETP |=>
        out_r[0] == ($past(hit_w[0]) ^ $past(out_neg[0])))
        else $error("set point output wrong"); // see R12
    out_image_a: assert property (clk_en && out_fn[2] == OF_IMAGE |=>
        out_r[2] == ($past(phys_w[0]) ^ $past(out_neg[2])))
        else $error("image output wrong"); // see R17
    out_level_a: assert property (clk_en && out_fn[1] == OF_LEVEL |=>
        out_r[1] == ($past(master_lvl[1]) ^ $past(out_neg[1])))
        else $error("requested level wrong"); // see R18
    out_defect_a: assert property (clk_en && out_fn[3] == OF_DEFECT |=>
        out_r[3] == ($past(alarm_r) ^ $past(out_neg[3])))
        else $error("defect output wrong"); // see R16
    alarm_min_a: assert property ($fell(alarm_r) |-> $past(al_on_r) >= $past(al_min_time))
        else $error("alarm dropped too early"); // see R23
    ana_error_a: assert property (clk_en && alarm_r && ana_src == AS_NET |=> ana_r == ANA_ERR)
        else $error("analog error value missing"); // see R19
    ana_cfg_a: assert property (1'b1 |=> $stable(acfg_r))
        else $error("analog config changed outside reset"); // see R20
    ramp_step_a: assert property (clk_en && ramp_gap > RAMP_STEP |=>
        ramp_r != $past(ramp_tgt))
        else $error("flow output stepped"); // see R21
endmodule : wlio_top
`default_nettype wire

// ---- tb/wlio_field.sv ----
`timescale 1ns/100ps
`default_nettype none
module wlio_field (
    input wire logic ref_clk,
    input wire logic [1:0] want,
    output logic [1:0] pin
);
    logic [1:0] held = 2'b00;
    logic [1:0] ph [2] = '{2'd0, 2'd0};
    initial pin = 2'b00;
    // Contacts bounce once per change, shorter than the bench debounce
    always @(negedge ref_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (want[i] !== held[i]) begin
                held[i] <= want[i];
                ph[i] <= 2'd2;
                pin[i] <= want[i];
            end else if (ph[i] == 2'd2) begin
                pin[i] <= ~want[i];
                ph[i] <= 2'd1;
            end else begin
                pin[i] <= want[i];
                ph[i] <= 2'd0;
            end
        end
    end
endmodule : wlio_field
`default_nettype wire

// ---- tb/tb_weighing_logic_io_functions.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_weighing_logic_io_functions;
    import wlio_pkg::*;
    logic ref_clk, rst, clk_en, stab_en, stable, legal_trade, raw_alarm, flow_run;
    logic [NIN-1:0] in_pin, in_neg, want;
    logic [TW-1:0] db_time, sample_period, al_db_time, al_min_time;
    wlio_in_fn_t in_fn [NIN];
    wlio_mode_t op_mode;
    logic [WW-1:0] capacity;
    wlio_w_t raw_gross, factory, sic_result, batch_val, ana_req, flow_cmd, iflow, aflow, speed;
    wlio_meas_t meas_sel;
    wlio_out_fn_t out_fn [NOUT];
    logic [NOUT-1:0] out_neg, sp_win, master_lvl, out_pin;
    wlio_sp_src_t sp_src [NOUT];
    wlio_w_t sp_low [NOUT];
    wlio_w_t sp_high [NOUT];
    wlio_ana_src_t ana_src;
    logic [ACW-1:0] ana_cfg, ana_cfg_act;
    wlio_w_t gross_out, net_out, tare_out, zero_out, xmit_val, ana_val;
    logic zero_rej, xmit_p, sic_p, dzero_p, start_p, clrt_p, brun_lvl, bfault_lvl, alarm;
    int mismatches = 0;
    int samples_checked = 0;
    int xcnt = 0;
    int zcnt = 0;
    int scnt = 0;

    wlio_top dut (.ref_clk, .rst, .clk_en, .in_pin, .in_neg, .db_time, .in_fn, .op_mode,
        .stab_en, .stable, .legal_trade, .capacity, .raw_gross, .factory, .meas_sel,
        .sample_period, .sic_result, .batch_val, .out_fn, .out_neg, .sp_src, .sp_low,
        .sp_high, .sp_win, .master_lvl, .raw_alarm, .al_db_time, .al_min_time, .ana_src,
        .ana_cfg, .ana_req, .flow_cmd, .flow_run, .iflow, .aflow, .speed, .out_pin,
        .gross_out, .net_out, .tare_out, .zero_out, .zero_rej, .xmit_p, .xmit_val, .sic_p,
        .dzero_p, .start_p, .clrt_p, .brun_lvl, .bfault_lvl, .alarm, .ana_val, .ana_cfg_act);
    wlio_field field (.ref_clk(ref_clk), .want(want), .pin(in_pin));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Pulses last one cycle, so count them at every edge
    always @(posedge ref_clk) begin
        if (xmit_p === 1'b1) xcnt++;
        if (zero_rej === 1'b1) zcnt++;
        if (sic_p === 1'b1) scnt++;
    end

    task results();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    task chk(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", nm, exp, got);
            mismatches++;
        end
    endtask : chk
    task w(int n);
        repeat (n) @(negedge ref_clk);
    endtask : w
    // Sync, debounce and output register all settle inside 12 cycles
    task press(int i, logic v);
        want[i] = v;
        w(12);
    endtask : press

    initial begin
        #(40 * 4000);
        mismatches++;
        results();
    end
    initial begin
        rst = 1'b1; clk_en = 1'b1; want = 2'b00; in_neg = 2'b10; db_time = 16'h0002;
        in_fn = '{IF_TARE, IF_CTARE}; op_mode = OM_XMTR; stab_en = 1'b0; stable = 1'b1;
        legal_trade = 1'b1; capacity = 32'h0000_03E8; raw_gross = 32'h0000_0064;
        factory = 32'h0000_0007; meas_sel = MS_GROSS; sample_period = 16'h0004;
        sic_result = 32'h0000_0000; batch_val = 32'h0000_0000; out_fn = '{4{OF_NONE}};
        out_neg = 4'b0100; sp_src = '{4{SS_GROSS}}; sp_low = '{4{32'h0000_0000}};
        sp_high = '{4{32'h0000_0064}}; sp_win = 4'b1000; master_lvl = 4'b0010;
        raw_alarm = 1'b0; al_db_time = 16'h0002; al_min_time = 16'h0000;
        ana_src = AS_NONE; ana_cfg = 5'h05; ana_req = 32'h0000_0000;
        flow_cmd = 32'h0000_0000; flow_run = 1'b0; iflow = 32'h0000_0000;
        aflow = 32'h0000_0000; speed = 32'h0000_0000;
        w(12);
        rst = 1'b0;
        ana_cfg = 5'h0A;
        press(0, 1'b1); chk("tare", 32'h0000_0064, tare_out);
        press(0, 1'b0); stab_en = 1'b1; stable = 1'b0; raw_gross = 32'h0000_00C8;
        press(0, 1'b1); chk("tare_unstable", 32'h0000_0064, tare_out);
        press(0, 1'b0); stab_en = 1'b0; stable = 1'b1;
        press(1, 1'b1); chk("ctare_rise", 32'h0000_0064, tare_out);
        press(1, 1'b0); chk("ctare_fall", 32'h0000_0000, tare_out);
        in_fn[0] = IF_ZERO; raw_gross = 32'h0000_0032;
        press(0, 1'b1); chk("zero_2pct", 32'h0000_0000, zero_out);
        chk("zero_rej", 1, zcnt);
        press(0, 1'b0); legal_trade = 1'b0;
        press(0, 1'b1); chk("zero_10pct", 32'h0000_0032, zero_out);
        press(0, 1'b0); in_fn[0] = IF_XMIT; raw_gross = 32'h0000_0050; xcnt = 0;
        press(0, 1'b1); press(0, 1'b0);
        chk("xmit_cnt", 1, xcnt);
        chk("xmit_val", 32'h0000_001E, xmit_val);
        // Input 2 back to positive logic, else its idle low pin reads as active
        in_fn = '{IF_WIN, IF_WIN}; in_neg = 2'b00; xcnt = 0;
        press(0, 1'b1); w(28); press(0, 1'b0); chk("win_in1", 0, xcnt);
        xcnt = 0;
        press(1, 1'b1); w(28); press(1, 1'b0);
        chk("win_rep", 1, (xcnt >= 8 && xcnt <= 12));
        op_mode = OM_BSCALE; xcnt = 0;
        press(1, 1'b1); press(1, 1'b0); chk("win_belt", 0, xcnt);
        in_fn = '{IF_BRUN, IF_SIC};
        press(0, 1'b1); chk("brun", 1, brun_lvl);
        // Check is fired while input 1 still holds brun_lvl high from the run press
        press(1, 1'b1); press(1, 1'b0); chk("sic", 1, scnt);
        press(0, 1'b0); chk("brun_off", 0, brun_lvl);
        chk("gross", 32'h0000_001E, gross_out);
        chk("net", 32'h0000_001E, net_out);
        op_mode = OM_XMTR; out_fn = '{OF_MOTION, OF_LEVEL, OF_IMAGE, OF_SETP};
        stable = 1'b0;
        press(0, 1'b1); chk("outs", 4'b1011, out_pin);
        sp_win = 4'b0000; sp_low[3] = 32'h0000_000A; sp_high[3] = 32'h0000_0014;
        raw_gross = 32'h0000_0041; w(6); chk("hyst_hold", 1, out_pin[3]);
        raw_gross = 32'h0000_0037; w(6); chk("hyst_clr", 0, out_pin[3]);
        out_fn[0] = OF_DEFECT; ana_src = AS_GROSS; raw_alarm = 1'b1; w(10);
        chk("defect", 1, out_pin[0]);
        chk("ana_err", ANA_ERR, ana_val);
        raw_alarm = 1'b0; w(10);
        chk("defect_off", 0, out_pin[0]);
        chk("ana_gross", 32'h0000_0005, ana_val);
        chk("ana_cfg", 5'h05, ana_cfg_act);
        results();
    end
endmodule : tb_weighing_logic_io_functions
`default_nettype wire
